/* logic/beep_gen.sv */
// Square-wave beep tone generator
`include "clock_unit_regs.svh"

module beep_gen
   import clock_unit_pkg::*;
#(
   parameter logic [12:0] HALF1 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ1_HZ)),
   parameter logic [12:0] HALF2 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ2_HZ)),
   parameter logic [12:0] HALF3 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ3_HZ))
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Control
   input wire logic [1:0] i_rate,
   input wire logic i_run,
   // Tone level
   output logic o_level
);

   logic [12:0] cnt_ff;
   logic [12:0] half;

   // Half period of the selected tone
   always_comb begin
      unique case (i_rate)
         2'h1: half = HALF1;
         2'h2: half = HALF2;
         2'h3: half = HALF3;
         default: half = HALF1;
      endcase
   end

   // Toggle every half period, park low when off, hold while frozen
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_ff <= 13'h0000;
         o_level <= 1'b0;
      end else if (i_rate == `BEEP_OFF) begin
         cnt_ff <= 13'h0000;
         o_level <= 1'b0;
      end else if (i_run) begin
         if (cnt_ff >= half - 13'h0001) begin
            cnt_ff <= 13'h0000;
            o_level <= ~o_level;
         end else begin
            cnt_ff <= cnt_ff + 13'h0001;
         end
      end
   end

endmodule

/* logic/clock_and_time_base_unit.sv */
// Main clock controller: processor clock divider, clock out, time base, beeper
`include "clock_unit_regs.svh"

// Notes on behaviour
// - Interrupt only when enabled and unmasked
// - Time base wakes active-halt, not halt
// - Select bit drives processor clock on pin; in normal mode the pin carries half the oscillator frequency
// - Clock out suppressed in active-halt
// - Slow divider: divide by 2, 4, 8, 16
// - Normal mode: processor clock equals oscillator
// - Periods 16000, 32000, 80000, 200000 cycles
// - New period applies after current one ends
// - Halt with enable set enters active-halt
// - Flag set on expiry, cleared by read
// - Beep off, 2 kHz, 1 kHz, 500 Hz
// - Beep keeps running in active-halt
// - Full halt freezes counter and control and beep registers
module clock_and_time_base_unit
   import clock_unit_pkg::*;
#(
   parameter logic [17:0] TB_PERIOD0 = `TB_PERIOD0,
   parameter logic [17:0] TB_PERIOD1 = `TB_PERIOD1,
   parameter logic [17:0] TB_PERIOD2 = `TB_PERIOD2,
   parameter logic [17:0] TB_PERIOD3 = `TB_PERIOD3,
   parameter logic [12:0] BEEP_HALF1 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ1_HZ)),
   parameter logic [12:0] BEEP_HALF2 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ2_HZ)),
   parameter logic [12:0] BEEP_HALF3 = 13'(`BEEP_REF_OSC_HZ / (2 * `BEEP_FREQ3_HZ))
) (
   // Oscillator clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   // Processor side
   input wire logic i_halt_req,
   input wire logic i_wake_irq,
   input wire logic i_irq_masked,
   output logic o_cpu_clk_en,
   output logic o_tb_irq_req,
   output logic o_wake,
   output power_state_t o_power_state,
   // Event interrupt
   output logic o_irq,
   // Port pins
   output pin_drive_t o_clock_out_pin,
   output pin_drive_t o_beep_pin
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   bus_req_t req_ff;
   logic pend_ff;
   ccs_t ccs_ff;
   logic flag_ff;
   logic [1:0] beep_rate_ff;
   logic [1:0] evt_ff;
   logic [1:0] evt_mask_ff;
   logic [1:0] nxt_evt;
   logic [17:0] tb_cnt_ff;
   logic [1:0] tb_cur_ff;
   logic [17:0] tb_period;
   logic expiry;
   logic [3:0] div_cnt_ff;
   logic div_tick;
   logic div_level;
   logic halted;
   logic acc_wr;
   logic acc_rd;
   logic sel_ccs;
   logic sel_beep;
   logic sel_evt;
   logic sel_mask;
   logic beep_level;
   logic [31:0] rd_word;
   logic wake_now;
   logic beep_oe_n_ff;

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------

   // Address phase capture; one wait state on every transfer
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         req_ff <= '0;
         pend_ff <= 1'b0;
         o_hreadyout <= 1'b1;
      end else if (pend_ff) begin
         pend_ff <= 1'b0;
         o_hreadyout <= 1'b1;
      end else if (i_hsel && i_htrans[`HTRANS_NONSEQ_BIT] && i_hready) begin
         req_ff.write <= i_hwrite;
         req_ff.in_range <= (i_haddr[`ADDR_HI_MSB:`ADDR_HI_LSB] == '0);
         req_ff.idx <= i_haddr[`IDX_MSB:`IDX_LSB];
         pend_ff <= 1'b1;
         o_hreadyout <= 1'b0;
      end
   end

   // Response is always OKAY
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_hresp <= `HRESP_OKAY;
      end else begin
         o_hresp <= `HRESP_OKAY;
      end
   end

   // Access strobes in the wait cycle of the data phase
   assign acc_wr = pend_ff && req_ff.write;
   assign acc_rd = pend_ff && !req_ff.write;
   assign sel_ccs = req_ff.in_range && (req_ff.idx == `CCS_INDEX);
   assign sel_beep = req_ff.in_range && (req_ff.idx == `BEEP_INDEX);
   assign sel_evt = req_ff.in_range && (req_ff.idx == `EVT_INDEX);
   assign sel_mask = req_ff.in_range && (req_ff.idx == `EVT_MASK_INDEX);

   // Read multiplexer; unmapped words read as zero
   always_comb begin
      rd_word = 32'h00000000;
      if (sel_ccs) begin
         rd_word[7:0] = {ccs_ff[7:1], flag_ff};
      end else if (sel_beep) begin
         rd_word[`BEEP_RATE_MSB:`BEEP_RATE_LSB] = beep_rate_ff;
      end else if (sel_evt) begin
         rd_word[1:0] = evt_ff;
      end else if (sel_mask) begin
         rd_word[1:0] = evt_mask_ff;
      end
   end

   // Read data register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_hrdata <= 32'h00000000;
      end else if (acc_rd) begin
         o_hrdata <= rd_word;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   assign halted = (o_power_state == PS_HALT);

   // Control fields; frozen in full halt
   // freeze in halt
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ccs_ff <= ccs_t'(`CCS_RESET);
      end else if (acc_wr && sel_ccs && !halted) begin
         ccs_ff <= ccs_t'({i_hwdata[7:1], 1'b0});
      end
   end

   // Beep rate; reserved upper bits are not stored
   // reserved bits dropped
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         beep_rate_ff <= `BEEP_RESET;
      end else if (acc_wr && sel_beep && !halted) begin
         beep_rate_ff <= i_hwdata[`BEEP_RATE_MSB:`BEEP_RATE_LSB];
      end
   end

   // Time-base flag: set on expiry, cleared by any read of the register
   // set wins clear
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flag_ff <= 1'b0;
      end else if (expiry) begin
         flag_ff <= 1'b1;
      end else if (acc_rd && sel_ccs) begin
         flag_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Event status, mask and interrupt line
   // ------------------------------------------------------------

   // Sticky events, write one to clear, a new event wins
   always_comb begin
      nxt_evt = evt_ff;
      if (acc_wr && sel_evt) begin
         nxt_evt = evt_ff & ~i_hwdata[1:0];
      end
      if (expiry) begin
         nxt_evt[`EVT_EXPIRY_BIT] = 1'b1;
      end
      if (wake_now) begin
         nxt_evt[`EVT_WAKE_BIT] = 1'b1;
      end
   end

   // Event status register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         evt_ff <= `EVT_RESET;
      end else begin
         evt_ff <= nxt_evt;
      end
   end

   // Event mask register, one lets the event through
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         evt_mask_ff <= `EVT_RESET;
      end else if (acc_wr && sel_mask) begin
         evt_mask_ff <= i_hwdata[1:0];
      end
   end

   // Level interrupt while an unmasked event is pending
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(nxt_evt & evt_mask_ff);
      end
   end

   // Processor time-base interrupt request
   // enable and global mask
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_tb_irq_req <= 1'b0;
      end else begin
         o_tb_irq_req <= flag_ff && ccs_ff.time_base_irq_enable && !i_irq_masked;
      end
   end

   // ------------------------------------------------------------
   // Time-base counter
   // ------------------------------------------------------------

   // Period of the selection in force
   // period table
   always_comb begin
      unique case (tb_cur_ff)
         2'h0: tb_period = TB_PERIOD0;
         2'h1: tb_period = TB_PERIOD1;
         2'h2: tb_period = TB_PERIOD2;
         2'h3: tb_period = TB_PERIOD3;
      endcase
   end

   assign expiry = !halted && (tb_cnt_ff == tb_period - 18'h00001);

   // Count oscillator cycles; load new selection only at expiry
   // defer selection change
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         tb_cnt_ff <= 18'h00000;
         tb_cur_ff <= 2'h0;
      end else if (expiry) begin
         tb_cnt_ff <= 18'h00000;
         tb_cur_ff <= ccs_ff.time_base_select;
      end else if (!halted) begin
         tb_cnt_ff <= tb_cnt_ff + 18'h00001;
      end
   end

   // ------------------------------------------------------------
   // Power state
   // ------------------------------------------------------------

   // Wake from active-halt on expiry or outside wake; halt only from outside
   // wake sources
   always_comb begin
      unique case (o_power_state)
         PS_ACTIVE_HALT: wake_now = expiry || i_wake_irq;
         PS_HALT: wake_now = i_wake_irq;
         default: wake_now = 1'b0;
      endcase
   end

   // Halt instruction picks active-halt when the interrupt is enabled
   // active-halt entry
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_power_state <= PS_RUN;
      end else begin
         unique case (o_power_state)
            PS_RUN: begin
               if (i_halt_req) begin
                  o_power_state <= ccs_ff.time_base_irq_enable ? PS_ACTIVE_HALT : PS_HALT;
               end
            end
            PS_ACTIVE_HALT: begin
               if (wake_now) begin
                  o_power_state <= PS_RUN;
               end
            end
            PS_HALT: begin
               if (wake_now) begin
                  o_power_state <= PS_RUN;
               end
            end
            default: o_power_state <= PS_RUN;
         endcase
      end
   end

   // One-cycle wake pulse to the processor
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_wake <= 1'b0;
      end else begin
         o_wake <= wake_now;
      end
   end

   // ------------------------------------------------------------
   // Processor clock divider and clock out
   // ------------------------------------------------------------

   // Free-running prescaler, stopped with the oscillator in halt
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         div_cnt_ff <= 4'h0;
      end else if (!halted) begin
         div_cnt_ff <= div_cnt_ff + 4'h1;
      end
   end

   // Tick and level of the selected rate
   // slow divider
   always_comb begin
      div_tick = 1'b1;
      div_level = div_cnt_ff[0];
      if (ccs_ff.slow_mode_select) begin
         unique case (ccs_ff.slow_clock_divider)
            2'h0: div_tick = (div_cnt_ff[0] == 1'b1);
            2'h1: div_tick = (div_cnt_ff[1:0] == 2'h3);
            2'h2: div_tick = (div_cnt_ff[2:0] == 3'h7);
            2'h3: div_tick = (div_cnt_ff == 4'hF);
         endcase
         div_level = div_cnt_ff[ccs_ff.slow_clock_divider];
      end
   end

   // Processor clock enable, silent in both halt modes
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_cpu_clk_en <= 1'b0;
      end else begin
         o_cpu_clk_en <= div_tick && (o_power_state == PS_RUN);
      end
   end

   // Clock out pin, released to the port when deselected or in active-halt
   // select drives pin
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_clock_out_pin <= '{o: 1'b0, oe_n: 1'b1};
      end else begin
         o_clock_out_pin.o <= div_level && (o_power_state == PS_RUN);
         o_clock_out_pin.oe_n <= !ccs_ff.cpu_clock_output_select ||
                                 (o_power_state == PS_ACTIVE_HALT);
      end
   end

   // ------------------------------------------------------------
   // Beeper
   // ------------------------------------------------------------

   // Tone generator runs in run and active-halt
   // beep in active-halt
   beep_gen #(
      .HALF1(BEEP_HALF1),
      .HALF2(BEEP_HALF2),
      .HALF3(BEEP_HALF3)
   ) u_beep (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_rate(beep_rate_ff),
      .i_run(!halted),
      .o_level(beep_level)
   );

   // Beep pin drive enable follows the rate selection
   // beep off releases pin
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         beep_oe_n_ff <= 1'b1;
      end else begin
         beep_oe_n_ff <= (beep_rate_ff == `BEEP_OFF);
      end
   end

   // Whole pin struct from one driver: tone flop and enable flop
   assign o_beep_pin = '{o: beep_level, oe_n: beep_oe_n_ff};

   // Size field is accepted for any width; registers are whole words
   logic unused_hsize;
   assign unused_hsize = ^i_hsize;

endmodule

/* logic/clock_unit_pkg.sv */
// Types shared by the clock and time-base unit
package clock_unit_pkg;

   // Clock control/status register layout, bit 7 down to bit 0
   typedef struct packed {
      logic cpu_clock_output_select;
      logic [1:0] slow_clock_divider;
      logic slow_mode_select;
      logic [1:0] time_base_select;
      logic time_base_irq_enable;
      logic time_base_flag;
   } ccs_t;

   // Power state of the processor as seen by this unit
   typedef enum logic [2:0] {
      PS_RUN = 3'h1,
      PS_ACTIVE_HALT = 3'h2,
      PS_HALT = 3'h4
   } power_state_t;

   // Latched bus address phase
   typedef struct packed {
      logic write;
      logic in_range;
      logic [7:0] idx;
   } bus_req_t;

   // Drive of one port pin: level and active-low output enable
   typedef struct packed {
      logic o;
      logic oe_n;
   } pin_drive_t;

endpackage

/* logic/clock_unit_regs.svh */
// Register indices, field values, reset values and timing counts of the clock unit
`ifndef CLOCK_UNIT_REGS_SVH
`define CLOCK_UNIT_REGS_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define CCS_INDEX 8'h2C
`define BEEP_INDEX 8'h2D
`define EVT_INDEX 8'h2E
`define EVT_MASK_INDEX 8'h2F
`define IDX_MSB 9
`define IDX_LSB 2
`define ADDR_HI_MSB 31
`define ADDR_HI_LSB 10

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define BEEP_RATE_MSB 1
`define BEEP_RATE_LSB 0
`define CCS_RESET 8'h00
`define BEEP_RESET 2'h0
`define BEEP_OFF 2'h0
`define EVT_EXPIRY_BIT 0
`define EVT_WAKE_BIT 1
`define EVT_RESET 2'h0

// ------------------------------------------------------------
// Bus encodings
// ------------------------------------------------------------
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'h0

// ------------------------------------------------------------
// Time-base periods in oscillator cycles (16000, 32000, 80000, 200000)
// ------------------------------------------------------------
`define TB_PERIOD0 18'h03E80
`define TB_PERIOD1 18'h07D00
`define TB_PERIOD2 18'h13880
`define TB_PERIOD3 18'h30D40

// ------------------------------------------------------------
// Beep rates: reference oscillator 8 MHz, tones 2000, 1000, 500 Hz
// ------------------------------------------------------------
`define BEEP_REF_OSC_HZ 32'h007A1200
`define BEEP_FREQ1_HZ 32'h000007D0
`define BEEP_FREQ2_HZ 32'h000003E8
`define BEEP_FREQ3_HZ 32'h000001F4

`endif

/* sim/clock_and_time_base_unit_tb.sv */
// Self-checking testbench of the clock and time-base unit
module clock_and_time_base_unit_tb
   import clock_unit_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER [4] = '{16, 32, 80, 200};
   // Beep half periods: code 01 shortened, 1 kHz and 500 Hz at 8 MHz
   localparam int HALF_EXP [4] = '{0, 4, 4000, 8000};
   logic [2:0] hsize = 3'h0;
   logic clk, hreadyout, hresp, cpu_clk_en, tb_irq_req, wake, irq;
   logic rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, halt_req = 1'b0;
   logic wake_irq = 1'b0, irq_masked = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   power_state_t pstate;
   pin_drive_t clk_pin, beep_pin;
   int bad_count = 0, checks_done = 0, cyc = 0;

   clock_and_time_base_unit #(.TB_PERIOD0(18'h00010), .TB_PERIOD1(18'h00020),
      .TB_PERIOD2(18'h00050), .TB_PERIOD3(18'h000C8), .BEEP_HALF1(13'h0004))
      u_clock_and_time_base_unit (
      .i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata), .i_halt_req(halt_req),
      .i_wake_irq(wake_irq), .i_irq_masked(irq_masked), .o_cpu_clk_en(cpu_clk_en),
      .o_tb_irq_req(tb_irq_req), .o_wake(wake), .o_power_state(pstate), .o_irq(irq),
      .o_clock_out_pin(clk_pin), .o_beep_pin(beep_pin));

   // -----------------------------------------------
   // Clock, cycle count and hang guard
   // -----------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         bad_count++;
         stop_test();
      end
   end

   // -----------------------------------------------
   // Shared tasks
   // -----------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Waits until ready is sampled high at a rising edge
   task automatic wait_ready();
      #1;
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      @(posedge clk);
   endtask
   // One single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= addr;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      wait_ready();
      rd = hrdata;
   endtask
   // Counts clock enables (0), clock-out toggles (1) or beep toggles (2)
   task automatic measure(input int which, input int len, output int cnt);
      logic last;
      cnt = 0;
      #1;
      last = (which == 1) ? clk_pin.o : beep_pin.o;
      repeat (len) begin
         @(posedge clk);
         #1;
         case (which)
            0: cnt += (cpu_clk_en === 1'b1);
            1: cnt += (clk_pin.o !== last);
            default: cnt += (beep_pin.o !== last);
         endcase
         last = (which == 1) ? clk_pin.o : beep_pin.o;
      end
   endtask
   // Cycles between two beep toggles, after a first toggle is seen
   task automatic half_period(output int n);
      logic last;
      n = 0;
      @(posedge clk);
      #1;
      last = beep_pin.o;
      while (beep_pin.o === last) begin
         @(posedge clk);
         #1;
      end
      last = beep_pin.o;
      while (beep_pin.o === last) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   // Waits for time-base request (0), event interrupt (1) or wake (2)
   task automatic wait_high(input int which, output int stamp);
      #1;
      while ((which == 0 ? tb_irq_req : which == 1 ? irq : wake) !== 1'b1) begin
         @(posedge clk);
         #1;
      end
      stamp = cyc;
   endtask

   // -----------------------------------------------
   // Scenarios
   // -----------------------------------------------
   task automatic t_regs();
      check(clk_pin, 32'h1);
      check(beep_pin, 32'h1);
      bus(0, 32'hB0, 32'h0);
      check(rd, 32'h0);
      bus(1, 32'hB4, 32'h3);
      bus(0, 32'hB4, 32'h0);
      check(rd, 32'h3);
      bus(1, 32'h100, 32'hFF);
      bus(0, 32'h100, 32'h0);
      check(rd, 32'h0);
      $display("regs test done");
   endtask
   task automatic t_clocks();
      int cnt;
      measure(0, 32, cnt);
      check(32'(cnt), 32'h20);
      bus(1, 32'hB0, 32'h80);
      measure(1, 16, cnt);
      check(32'(cnt), 32'h10);
      check(clk_pin.oe_n, 1'b0);
      for (int d = 0; d < 4; d++) begin
         bus(1, 32'hB0, 32'h90 | 32'(d << 5));
         repeat (20) @(posedge clk);
         measure(0, 64, cnt);
         check(32'(cnt), 32'(64 >> (d + 1)));
         measure(1, 64, cnt);
         check(32'(cnt), 32'(64 >> d));
      end
      for (int b = 1; b < 4; b++) begin
         bus(1, 32'hB4, 32'(b));
         half_period(cnt);
         check(32'(cnt), 32'(HALF_EXP[b]));
         check(beep_pin.oe_n, 1'b0);
      end
      bus(1, 32'hB4, 32'h0);
      bus(1, 32'hB0, 32'h0);
      check(beep_pin, 32'h1);
      $display("clocks test done");
   endtask
   task automatic t_time_base();
      int s0, s1, s2;
      bus(1, 32'hB0, 32'h02);
      wait_high(0, s0);
      bus(0, 32'hB0, 32'h0);
      wait_high(0, s0);
      bus(0, 32'hB0, 32'h0);
      check(rd, 32'h3);
      bus(0, 32'hB0, 32'h0);
      check(rd, 32'h2);
      for (int c = 1; c < 4; c++) begin
         bus(1, 32'hB0, 32'h02 | 32'(c << 2));
         wait_high(0, s1);
         check(32'(s1 - s0), 32'(PER[c - 1]));
         bus(0, 32'hB0, 32'h0);
         check(rd, 32'h3 | 32'(c << 2));
         wait_high(0, s2);
         check(32'(s2 - s1), 32'(PER[c]));
         bus(0, 32'hB0, 32'h0);
         s0 = s2;
      end
      $display("time base test done");
   endtask
   task automatic t_irq();
      int s;
      irq_masked <= 1'b1;
      bus(1, 32'hBC, 32'h1);
      bus(1, 32'hB8, 32'h3);
      wait_high(1, s);
      check(tb_irq_req, 1'b0);
      bus(0, 32'hB8, 32'h0);
      check(rd, 32'h1);
      bus(1, 32'hBC, 32'h0);
      #1 check(irq, 1'b0);
      bus(1, 32'hB8, 32'h1);
      bus(0, 32'hB8, 32'h0);
      check(rd, 32'h0);
      irq_masked <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check(tb_irq_req, 1'b1);
      $display("interrupt test done");
   endtask
   task automatic t_power();
      int cnt, s;
      bus(1, 32'hB0, 32'h8E);
      bus(1, 32'hB4, 32'h1);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      measure(2, 16, cnt);
      check(pstate, PS_ACTIVE_HALT);
      check(clk_pin.oe_n, 1'b1);
      check(32'(cnt), 32'h4);
      wait_high(2, s);
      check(pstate, PS_RUN);
      bus(1, 32'hB0, 32'h0C);
      halt_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      measure(2, 300, cnt);
      check(pstate, PS_HALT);
      check(32'(cnt), 32'h0);
      bus(1, 32'hB0, 32'h80);
      wake_irq <= 1'b1;
      @(posedge clk);
      wake_irq <= 1'b0;
      wait_high(2, s);
      check(pstate, PS_RUN);
      bus(0, 32'hB0, 32'h0);
      check(rd & 32'hFE, 32'h0C);
      $display("power test done");
   endtask

   // -----------------------------------------------
   // Main sequence
   // -----------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_clocks();
      t_time_base();
      t_irq();
      t_power();
      stop_test();
   end
endmodule

/* sim/clock_unit_properties.sv */
// Port checker of the clock and time-base unit, bound to its top module
module clock_unit_chk
   import clock_unit_pkg::*;
(
   // Clock, reset and bus
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_hsel,
   input wire logic [1:0] i_htrans,
   input wire logic i_hready,
   input wire logic o_hreadyout,
   input wire logic o_hresp,
   // Processor side and pins
   input wire logic i_halt_req,
   input wire logic i_wake_irq,
   input wire logic i_irq_masked,
   input wire logic o_cpu_clk_en,
   input wire logic o_tb_irq_req,
   input wire logic o_wake,
   input wire power_state_t o_power_state,
   input wire pin_drive_t o_clock_out_pin
);
   // -----------------------------------------------
   // Clocking and bus sequences
   // -----------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_taken;
      i_hsel && i_htrans[1] && i_hready && o_hreadyout;
   endsequence
   sequence s_one_wait;
      !o_hreadyout ##1 o_hreadyout;
   endsequence

   // -----------------------------------------------
   // Assertions
   // -----------------------------------------------
   AST_ONE_WAIT: assert property (s_taken |=> s_one_wait)
      else $error("transfer did not take exactly one wait state");
   AST_OKAY: assert property (o_hresp == 1'h0)
      else $error("bus response not okay");
   AST_IRQ_MASKED: assert property (o_tb_irq_req |-> !$past(i_irq_masked))
      else $error("time-base request while globally masked");
   AST_HALT_HOLD: assert property (
      o_power_state == PS_HALT && !i_wake_irq |=> o_power_state == PS_HALT)
      else $error("full halt left without a wake interrupt");
   AST_HALT_WAKE: assert property (
      o_power_state == PS_HALT && i_wake_irq |-> ##[1:2] o_wake)
      else $error("no wake pulse after wake interrupt in halt");
   AST_WAKE_PULSE: assert property (o_wake |=> !o_wake)
      else $error("wake pulse longer than one cycle");
   AST_AH_CLKOUT: assert property (
      o_power_state == PS_ACTIVE_HALT && $past(o_power_state) == PS_ACTIVE_HALT
      |-> o_clock_out_pin.oe_n)
      else $error("clock out driven in active-halt");
   AST_HALTED_NO_CLK: assert property (
      o_power_state != PS_RUN && $past(o_power_state) != PS_RUN |-> !o_cpu_clk_en)
      else $error("processor clock enable while halted");
   AST_ENTER_HALT: assert property (
      o_power_state == PS_RUN && i_halt_req
      |=> o_power_state inside {PS_ACTIVE_HALT, PS_HALT})
      else $error("halt request did not leave run state");
endmodule

bind clock_and_time_base_unit clock_unit_chk u_clock_unit_chk (.i_clk, .i_rst_n, .i_hsel,
   .i_htrans, .i_hready, .o_hreadyout, .o_hresp, .i_halt_req, .i_wake_irq, .i_irq_masked,
   .o_cpu_clk_en, .o_tb_irq_req, .o_wake, .o_power_state, .o_clock_out_pin);
